// file: vic_pkg.sv
// constants, register map and carrier types for the voice path
package vic_pkg;
  // register offsets (byte addresses on the register port)
  localparam logic [15:0] A_TXP_MODE = 16'h252D;
  localparam logic [15:0] A_RX_CTRL = 16'h2538;
  localparam logic [15:0] A_RX_SDIV = 16'h253A;
  localparam logic [15:0] A_RX_MDIV = 16'h253B;
  localparam logic [15:0] A_RX_BDIV = 16'h253C;
  localparam logic [15:0] A_RX_MODE = 16'h253D;
  localparam logic [15:0] A_ENC_CTRL = 16'h2745;
  localparam logic [15:0] A_ENC_MH = 16'h2746;
  localparam logic [15:0] A_ENC_ML = 16'h2747;
  localparam logic [15:0] A_DEC_CTRL = 16'h274D;
  localparam logic [15:0] A_DEC_MH = 16'h274E;
  localparam logic [15:0] A_DEC_ML = 16'h274F;
  localparam logic [15:0] A_TXF_DATA = 16'h2750;
  localparam logic [15:0] A_TXF_MUTE = 16'h2751;
  localparam logic [15:0] A_TXF_CTRL = 16'h2752;
  localparam logic [15:0] A_TXF_RP = 16'h2753;
  localparam logic [15:0] A_TXF_WP = 16'h2754;
  localparam logic [15:0] A_TXF_STS = 16'h275A;
  localparam logic [15:0] A_DMA_LEN = 16'h275B;
  localparam logic [15:0] A_TXF_ERR = 16'h275C;
  // values after reset and storable bits
  localparam logic [7:0] RX_CTRL_RST = 8'hC0;
  localparam logic [7:0] RX_MODE_RST = 8'h7E;
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam logic [7:0] ENC_RW_MASK = 8'h3D;
  localparam logic [7:0] DEC_RW_MASK = 8'hBD;
  // field positions: interface control
  localparam int B_MS = 7, F_FMT = 5, F_WL = 3, B_SWAP = 2, B_FPOL = 1, B_BINV = 0;
  // field positions: port mode
  localparam int B_CLOCK_SHARE = 7, B_MASTER_CLOCK_IDLE_LEVEL = 6, B_FEDGE = 5, B_WIDE = 4, B_PUSH = 3, F_CHM = 1, B_CLKEN = 0;
  // field positions: codec control
  localparam int B_LPB = 7, B_CWIDE = 5, B_CMUT = 4, F_ALG = 2, B_INI = 1, B_ENA = 0;
  // field positions: fifo control, status and error
  localparam int B_DMA = 3, B_FMUT = 2, B_CLR = 1, B_FILL = 0;
  localparam int B_ZERO = 4, B_PSH = 3, B_POP = 2, B_OVF = 1, B_UDF = 0;
  // fifo size and word lengths per code
  localparam int TXF_DEPTH = 128;
  localparam logic [6:0] FILL_LAST = 7'h7F;
  localparam logic [5:0] WL_BITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  // modes
  typedef enum logic [1:0] {FMT_I2S, FMT_LJ, FMT_RJ, FMT_DSP} vic_fmt_t;
  typedef enum logic [1:0] {CH_ZERO, CH_RIGHT, CH_LEFT, CH_BOTH} vic_chm_t;
  typedef enum logic [1:0] {ALG_NONE, ALG_MULAW, ALG_ALAW, ALG_ADPCM} vic_alg_t;
  // carriers
  typedef struct packed {
    logic valid;
    vic_alg_t alg;
    logic wide;
    logic init;
    logic [15:0] data;
  } vic_codec_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } vic_byte_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } vic_word_t;
endpackage

// file: vic_voice.sv
// voice receive port, codec control, voice transmit fifo and its dma
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module vic_voice
  import vic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial pins of the receive port
  output logic mclk_o,
  output logic mclk_oe,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  input wire logic frame_clock_i,
  output logic frame_clock_o,
  output logic frame_clock_oe,
  input wire logic sdata_i,
  // transmit port clocks and enable
  input wire logic tx_bclk,
  input wire logic tx_frame_clock,
  output logic tx_port_enable,
  // codec engine
  output vic_codec_req_t enc_req,
  input wire vic_byte_t enc_res,
  output vic_codec_req_t dec_req,
  input wire vic_byte_t dec_src,
  input wire vic_word_t dec_res,
  output vic_word_t dec_pcm,
  // radio mac side
  output vic_byte_t mac_tx,
  input wire logic mac_ready
);

  logic [7:0] rx_ctrl_q, sdiv_q, mdiv_q, bdiv_q, rx_mode_q, txp_q;
  logic [7:0] enc_ctrl_q, dec_ctrl_q, emh_q, eml_q, dmh_q, dml_q;
  logic [7:0] fmute_q, rp_q, wp_q, dma_len_q, dma_rem_q, rdata_q;
  logic fmut_q, ovf_q, udf_q, fill_q;
  logic [6:0] fill_idx_q;
  logic [7:0] fifo_mem [TXF_DEPTH];

  // register writes that steer the block
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ctrl_q <= RX_CTRL_RST;
      rx_mode_q <= RX_MODE_RST;
      {sdiv_q, mdiv_q, bdiv_q, txp_q, enc_ctrl_q, dec_ctrl_q} <= {6{REG_ZERO}};
      {emh_q, eml_q, dmh_q, dml_q, fmute_q, dma_len_q} <= {6{REG_ZERO}};
      fmut_q <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        A_TXP_MODE: txp_q <= {7'h00, reg_wdata[B_CLKEN]};
        A_RX_CTRL: rx_ctrl_q <= reg_wdata;
        A_RX_SDIV: sdiv_q <= reg_wdata;
        A_RX_MDIV: mdiv_q <= reg_wdata;
        A_RX_BDIV: bdiv_q <= reg_wdata;
        A_RX_MODE: rx_mode_q <= reg_wdata;
        A_ENC_CTRL: enc_ctrl_q <= reg_wdata & ENC_RW_MASK;
        A_ENC_MH: emh_q <= reg_wdata;
        A_ENC_ML: eml_q <= reg_wdata;
        A_DEC_CTRL: dec_ctrl_q <= reg_wdata & DEC_RW_MASK;
        A_DEC_MH: dmh_q <= reg_wdata;
        A_DEC_ML: dml_q <= reg_wdata;
        A_TXF_MUTE: fmute_q <= reg_wdata;
        A_TXF_CTRL: fmut_q <= reg_wdata[B_FMUT];
        A_DMA_LEN: dma_len_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // field decode
  wire master = rx_ctrl_q[B_MS];
  wire vic_fmt_t fmt = vic_fmt_t'(rx_ctrl_q[F_FMT+:2]);
  wire [1:0] wl = rx_ctrl_q[F_WL+:2];
  wire [5:0] wlb = WL_BITS[wl];
  wire swap = rx_ctrl_q[B_SWAP];
  wire fpol = rx_ctrl_q[B_FPOL];
  wire binv = rx_ctrl_q[B_BINV];
  wire share = rx_mode_q[B_CLOCK_SHARE];
  wire master_clock_idle_level = rx_mode_q[B_MASTER_CLOCK_IDLE_LEVEL];
  wire fedge = rx_mode_q[B_FEDGE];
  wire wide = rx_mode_q[B_WIDE];
  wire push = rx_mode_q[B_PUSH];
  wire vic_chm_t chm = vic_chm_t'(rx_mode_q[F_CHM+:2]);
  wire en = rx_mode_q[B_CLKEN];
  wire dsp = (fmt == FMT_DSP);
  assign tx_port_enable = txp_q[B_CLKEN];

  // master clock: half period of sdiv system clocks
  logic [7:0] mcnt_q;
  logic mclk_q;
  wire mclk_run = master && en && (sdiv_q != 8'h00);
  wire mclk_tog = mclk_run && (mcnt_q == sdiv_q - 8'h01);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mcnt_q <= 8'h00;
      mclk_q <= 1'b1;
    end else if (!mclk_run) begin
      mcnt_q <= 8'h00;
      mclk_q <= ~master_clock_idle_level;
    end else begin
      mcnt_q <= mclk_tog ? 8'h00 : mcnt_q + 8'h01;
      mclk_q <= mclk_q ^ mclk_tog;
    end
  end

  // bit clock: counts master clock half periods
  logic [8:0] bcnt_q;
  logic bclk_q;
  wire bclk_run = mclk_run && (mdiv_q != 8'h00);
  // an sdiv of exactly one takes the plain form of mdiv, every other sdiv the doubled form
  wire [8:0] blim = (sdiv_q == 8'h01) ? {1'b0, mdiv_q} : {mdiv_q, 1'b0};
  wire btog = bclk_run && mclk_tog && (bcnt_q == blim - 9'h001);
  wire b_rise = btog && !bclk_q;
  wire b_fall = btog && bclk_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bcnt_q <= 9'h000;
      bclk_q <= 1'b0;
    end else if (!bclk_run) begin
      bcnt_q <= 9'h000;
      bclk_q <= 1'b0;
    end else if (mclk_tog) begin
      bcnt_q <= btog ? 9'h000 : bcnt_q + 9'h001;
      bclk_q <= bclk_q ^ btog;
    end
  end

  // frame clock: one step per bit clock period on the chosen edge
  logic [7:0] fcnt_q;
  logic frame_clock_q;
  wire frame_run = bclk_run && (bdiv_q != 8'h00);
  wire f_ev = fedge ? b_rise : b_fall;
  wire f_wrap = (fcnt_q == bdiv_q - 8'h01);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fcnt_q <= 8'h00;
      frame_clock_q <= 1'b0;
    end else if (!frame_run) begin
      fcnt_q <= 8'h00;
      frame_clock_q <= 1'b0;
    end else if (f_ev) begin
      fcnt_q <= f_wrap ? 8'h00 : fcnt_q + 8'h01;
      frame_clock_q <= dsp ? f_wrap : (frame_clock_q ^ f_wrap);
    end
  end

  // pins are driven only while the port is master and enabled
  wire drive = master && en;
  assign mclk_o = mclk_q;
  assign bclk_o = bclk_q ^ binv;
  assign frame_clock_o = frame_clock_q;
  assign mclk_oe = drive;
  assign bclk_oe = drive;
  assign frame_clock_oe = drive;

  // pin synchronisers {data, frame, bit}; a level is taken once stages two and three agree
  logic [2:0] sy1_q, sy2_q, sy3_q, syf_q;
  wire [2:0] agree = ~(sy2_q ^ sy3_q);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sy1_q, sy2_q, sy3_q, syf_q} <= 12'h000;
    end else begin
      sy1_q <= {sdata_i, frame_clock_i, bclk_i};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      syf_q <= (agree & sy3_q) | (~agree & syf_q);
    end
  end

  // clock source: own clocks, shared transmit clocks or pins
  wire slave_b = share ? tx_bclk : syf_q[0];
  wire slave_l = share ? tx_frame_clock : syf_q[1];
  wire src_b = master ? bclk_q : (slave_b ^ binv);
  wire src_l = master ? frame_clock_q : slave_l;
  wire src_d = syf_q[2];

  // receiver: sample on the rising edge of the normalised bit clock
  logic bn_q, lr_q, cur_right_q, primed_q;
  logic [6:0] cnt_q;
  logic [31:0] sh_q;
  wire samp = en && src_b && !bn_q;
  wire raw_right = (fmt == FMT_I2S) ? src_l : ~src_l;
  wire right_now = raw_right ^ fpol ^ swap;
  wire chg = right_now != cur_right_q;
  wire dsp_start = src_l && !lr_q;
  wire [6:0] cnt_base = (dsp ? dsp_start : chg) ? 7'h00 : cnt_q;
  wire [31:0] sh_base = (!dsp && chg) ? 32'h0000_0000 : sh_q;
  wire take_i2s = (cnt_base != 7'h00) && (cnt_base <= {1'b0, wlb});
  wire take_dsp = (cnt_base != 7'h00) && (cnt_base <= {wlb, 1'b0});
  wire take = dsp ? take_dsp : (fmt == FMT_RJ) ? 1'b1 :
              (fmt == FMT_I2S) ? take_i2s : (cnt_base < {1'b0, wlb});
  wire [31:0] sh_shift = take ? {sh_base[30:0], src_d} : sh_base;
  wire slot0 = cnt_base == {1'b0, wlb};
  wire dsp_emit = dsp && take && (slot0 || cnt_base == {wlb, 1'b0});
  wire emit = samp && (dsp ? dsp_emit : (chg && primed_q));
  wire [31:0] ew = dsp ? sh_shift : sh_q;
  wire emit_right = dsp ? (!slot0 ^ swap) : cur_right_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {bn_q, lr_q, cur_right_q, primed_q} <= 4'h0;
      cnt_q <= 7'h00;
      sh_q <= 32'h0000_0000;
    end else if (!en) begin
      {bn_q, lr_q, cur_right_q, primed_q} <= 4'h0;
      cnt_q <= 7'h00;
      sh_q <= 32'h0000_0000;
    end else begin
      bn_q <= src_b;
      if (samp) begin
        lr_q <= src_l;
        cur_right_q <= right_now;
        primed_q <= primed_q | chg;
        cnt_q <= (cnt_base == 7'h7F) ? cnt_base : cnt_base + 7'h01;
        sh_q <= dsp_emit ? 32'h0000_0000 : sh_shift;
      end
    end
  end

  // word to 16 bits, channel mode, then forward width
  wire [15:0] aligned = (wl == 2'h0) ? ew[15:0] : (wl == 2'h1) ? ew[19:4] :
                        (wl == 2'h2) ? ew[23:8] : ew[31:16];
  wire pass = (chm == CH_BOTH) || (chm == CH_RIGHT && emit_right) ||
              (chm == CH_LEFT && !emit_right);
  wire [15:0] chv = pass ? aligned : 16'h0000;
  wire fwd = emit && push;
  wire [15:0] fwd_data = wide ? chv : {8'h00, chv[15:8]};

  // codec control
  wire enc_ini = reg_wr && (reg_addr == A_ENC_CTRL) && reg_wdata[B_INI];
  wire dec_ini = reg_wr && (reg_addr == A_DEC_CTRL) && reg_wdata[B_INI];
  wire enc_mut = enc_ctrl_q[B_CMUT];
  wire dec_mut = dec_ctrl_q[B_CMUT];
  wire codec_loopback = dec_ctrl_q[B_LPB];
  wire vic_byte_t dec_in = codec_loopback ? enc_res : dec_src;
  vic_codec_req_t enc_q, dec_q;
  vic_word_t pcm_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enc_q <= '0;
      dec_q <= '0;
      pcm_q <= '0;
    end else begin
      enc_q.valid <= fwd && enc_ctrl_q[B_ENA];
      enc_q.alg <= vic_alg_t'(enc_ctrl_q[F_ALG+:2]);
      enc_q.wide <= enc_ctrl_q[B_CWIDE];
      enc_q.init <= enc_ini;
      enc_q.data <= enc_mut ? {emh_q, eml_q} : fwd_data;
      dec_q.valid <= dec_in.valid && dec_ctrl_q[B_ENA];
      dec_q.alg <= vic_alg_t'(dec_ctrl_q[F_ALG+:2]);
      dec_q.wide <= dec_ctrl_q[B_CWIDE];
      dec_q.init <= dec_ini;
      dec_q.data <= {8'h00, dec_in.data};
      pcm_q.valid <= dec_res.valid && dec_ctrl_q[B_ENA];
      pcm_q.data <= dec_mut ? {dmh_q, dml_q} : dec_res.data;
    end
  end
  assign enc_req = enc_q;
  assign dec_req = dec_q;
  assign dec_pcm = pcm_q;

  // transmit fifo decode; a software write beside an encoder byte wins and loses that byte
  wire f_clr = reg_wr && (reg_addr == A_TXF_CTRL) && reg_wdata[B_CLR];
  wire f_fill = reg_wr && (reg_addr == A_TXF_CTRL) && reg_wdata[B_FILL];
  wire f_dma = reg_wr && (reg_addr == A_TXF_CTRL) && reg_wdata[B_DMA];
  wire sw_push = reg_wr && (reg_addr == A_TXF_DATA);
  wire sw_pop = reg_rd && (reg_addr == A_TXF_DATA);
  wire empty = (wp_q == rp_q);
  wire full = ((wp_q ^ rp_q) == 8'h80);
  wire push_req = sw_push || enc_res.valid;
  wire [7:0] push_data = sw_push ? reg_wdata : enc_res.data;
  wire push_ok = push_req && !full && !fill_q && !f_clr;
  wire dma_pop = (dma_rem_q != 8'h00) && mac_ready && !sw_pop && !empty && !fill_q;
  wire pop_ok = ((sw_pop && !empty && !fill_q) || dma_pop) && !f_clr;
  wire ovf_set = (push_req && full) || (sw_push && enc_res.valid);
  wire udf_set = sw_pop && empty;
  wire [7:0] head = fmut_q ? fmute_q : fifo_mem[rp_q[6:0]];

  // storage; fill walks every entry writing the mute value
  always_ff @(posedge ref_clk) begin
    if (fill_q) begin
      fifo_mem[fill_idx_q] <= fmute_q;
    end else if (push_ok) begin
      fifo_mem[wp_q[6:0]] <= push_data;
    end
  end

  // pointers and flags; a new error beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {rp_q, wp_q} <= 16'h0000;
      {ovf_q, udf_q, fill_q} <= 3'h0;
      fill_idx_q <= 7'h00;
    end else begin
      if (f_clr) begin
        {rp_q, wp_q} <= 16'h0000;
      end else begin
        if (reg_wr && reg_addr == A_TXF_WP) begin
          wp_q <= reg_wdata;
        end else if (push_ok) begin
          wp_q <= wp_q + 8'h01;
        end
        if (reg_wr && reg_addr == A_TXF_RP) begin
          rp_q <= reg_wdata;
        end else if (pop_ok) begin
          rp_q <= rp_q + 8'h01;
        end
      end
      ovf_q <= ovf_set || (ovf_q && !f_clr);
      udf_q <= udf_set || (udf_q && !f_clr);
      if (f_fill) begin
        fill_q <= 1'b1;
        fill_idx_q <= 7'h00;
      end else if (fill_q) begin
        fill_q <= (fill_idx_q != FILL_LAST);
        fill_idx_q <= fill_idx_q + 7'h01;
      end
    end
  end

  // dma: start bit never stores, it only loads the byte count
  vic_byte_t mac_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_rem_q <= 8'h00;
      mac_q <= '0;
    end else begin
      if (f_dma) begin
        dma_rem_q <= dma_len_q;
      end else if (dma_pop || f_clr) begin
        dma_rem_q <= f_clr ? 8'h00 : dma_rem_q - 8'h01;
      end
      mac_q.valid <= dma_pop && !f_clr;
      mac_q.data <= head;
    end
  end
  assign mac_tx = mac_q;

  // read selection; data port reads return the head byte and pop it
  logic [7:0] rd_mux;
  wire [7:0] sts = {3'h0, fill_q, push_ok, pop_ok || (dma_rem_q != 8'h00), 2'h0};
  always_comb begin
    case (reg_addr)
      A_TXP_MODE: rd_mux = txp_q;
      A_RX_CTRL: rd_mux = rx_ctrl_q;
      A_RX_SDIV: rd_mux = sdiv_q;
      A_RX_MDIV: rd_mux = mdiv_q;
      A_RX_BDIV: rd_mux = bdiv_q;
      A_RX_MODE: rd_mux = rx_mode_q;
      A_ENC_CTRL: rd_mux = enc_ctrl_q;
      A_ENC_MH: rd_mux = emh_q;
      A_ENC_ML: rd_mux = eml_q;
      A_DEC_CTRL: rd_mux = dec_ctrl_q;
      A_DEC_MH: rd_mux = dmh_q;
      A_DEC_ML: rd_mux = dml_q;
      A_TXF_DATA: rd_mux = (empty && !fmut_q) ? 8'h00 : head;
      A_TXF_MUTE: rd_mux = fmute_q;
      A_TXF_CTRL: rd_mux = {5'h00, fmut_q, 2'h0};
      A_TXF_RP: rd_mux = rp_q;
      A_TXF_WP: rd_mux = wp_q;
      A_TXF_STS: rd_mux = sts;
      A_DMA_LEN: rd_mux = dma_len_q;
      A_TXF_ERR: rd_mux = {6'h00, ovf_q, udf_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

endmodule // vic_voice

// file: vic_voice_props.sv
// checker: port-level timing relations of the voice block
`timescale 1ns/1ps
module vic_voice_props
  import vic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and streams
  input wire logic mclk_oe,
  input wire logic bclk_oe,
  input wire logic frame_clock_oe,
  input wire logic tx_port_enable,
  input wire vic_codec_req_t enc_req,
  input wire vic_byte_t enc_res,
  input wire vic_codec_req_t dec_req,
  input wire vic_byte_t dec_src,
  input wire vic_word_t dec_res,
  input wire vic_word_t dec_pcm,
  input wire vic_byte_t mac_tx,
  input wire logic mac_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // steps of the dma hand-off and of the loopback hop
  sequence s_mac_take;
    mac_ready ##1 mac_tx.valid;
  endsequence
  sequence s_loop_hop;
    enc_res.valid ##1 dec_req.valid;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data present without a read");
  a_pins_enable_together: assert property (mclk_oe == bclk_oe && bclk_oe == frame_clock_oe)
    else $error("clock pin enables disagree");
  a_oe_after_write: assert property ($changed(mclk_oe) |-> $past(reg_wr))
    else $error("clock pin enable moved without a write");
  a_txport_by_write: assert property ($changed(tx_port_enable) |-> $past(reg_wr) && $past(reg_addr) == A_TXP_MODE)
    else $error("transmit port enable moved without its write");
  a_mac_needs_ready: assert property (mac_tx.valid |-> $past(mac_ready))
    else $error("dma byte sent to a mac that was not ready");
  a_enc_pulse_single: assert property (enc_req.valid |=> !enc_req.valid)
    else $error("encoder request longer than one cycle");
  a_init_pulse_single: assert property (enc_req.init |=> !enc_req.init)
    else $error("encoder initialise longer than one cycle");
  a_dec_req_cause: assert property (dec_req.valid |-> $past(enc_res.valid || dec_src.valid))
    else $error("decoder request without a source byte");
  a_pcm_cause: assert property (dec_pcm.valid |-> $past(dec_res.valid))
    else $error("decoder output without an engine result");
  c_mac_take: cover property (s_mac_take);
  c_loop_hop: cover property (s_loop_hop);
endmodule // vic_voice_props

bind vic_voice vic_voice_props i_props (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mclk_oe(mclk_oe), .bclk_oe(bclk_oe),
  .frame_clock_oe(frame_clock_oe), .tx_port_enable(tx_port_enable), .enc_req(enc_req), .enc_res(enc_res),
  .dec_req(dec_req), .dec_src(dec_src), .dec_res(dec_res), .dec_pcm(dec_pcm), .mac_tx(mac_tx),
  .mac_ready(mac_ready));

// file: vic_adc_model.sv
// partner: left justified serial adc slaved to the port's clocks
`timescale 1ns/1ps
module vic_adc_model
(
  // clocks from the port
  input wire logic bclk,
  input wire logic frame_clock,
  // words sent while the frame clock is high or low
  input wire logic [15:0] hi_word,
  input wire logic [15:0] lo_word,
  // serial data to the port
  output logic sdata
);
  logic [15:0] sh = 16'h0000;
  logic last_q = 1'b0;
  // shift on falling bit clock; the 1 ns wait lets the frame clock settle first
  always @(negedge bclk) begin
    #1;
    if (frame_clock !== last_q) begin
      sh = frame_clock ? hi_word : lo_word;
      last_q = frame_clock;
    end else begin
      sh = {sh[14:0], ~sh[0]}; // past the word the line keeps changing, never holds
    end
  end
  // one driver for the line: it always shows the top bit of the shifter
  assign sdata = sh[15];
endmodule // vic_adc_model

// file: voice_i2s_rx_codec_txfifo_tb_top.sv
// testbench: registers, fifo, dma and serial receive of the voice block
`timescale 1ns/1ps
module voice_i2s_rx_codec_txfifo_tb_top
  import vic_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mac_ready = 1'b0;
  logic [15:0] reg_addr = 16'h0000, hi_w = 16'h0000, lo_w = 16'h0000;
  logic [15:0] lastw = 16'h0000, pcm_seen = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic mclk_o, mclk_oe, bclk_o, bclk_oe, frame_clock_o, frame_clock_oe, sdata, tx_port_enable;
  vic_codec_req_t enc_req, dec_req;
  vic_byte_t enc_res = '0, mac_tx;
  vic_word_t dec_res = '0, dec_pcm;
  logic [7:0] bank [128];
  logic [7:0] macq [$];
  int err_total = 0, checks_done = 0, cyc = 0, seed = 32'hd233925f, n, nh, nl;
  logic [2:0] clks;
  assign clks = {frame_clock_o, bclk_o, mclk_o};
  always #2.5 ref_clk = ~ref_clk;
  vic_voice i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mclk_o(mclk_o), .mclk_oe(mclk_oe),
    .bclk_i(1'b0), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .frame_clock_i(1'b0), .frame_clock_o(frame_clock_o), .frame_clock_oe(frame_clock_oe),
    .sdata_i(sdata), .tx_bclk(cyc[3]), .tx_frame_clock(cyc[8]), .tx_port_enable(tx_port_enable),
    .enc_req(enc_req), .enc_res(enc_res), .dec_req(dec_req), .dec_src('0), .dec_res(dec_res),
    .dec_pcm(dec_pcm), .mac_tx(mac_tx), .mac_ready(mac_ready));
  // as a slave the port and the adc both follow the shared transmit clocks
  vic_adc_model i_adc (.bclk(bclk_oe ? bclk_o : cyc[3]), .frame_clock(frame_clock_oe ? frame_clock_o : cyc[8]), .hi_word(hi_w),
    .lo_word(lo_w), .sdata(sdata));
  // codec engine stand-ins, random mac readiness, dma capture and the hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    mac_ready <= 1'($random(seed));
    enc_res <= '{enc_req.valid, enc_req.data[15:8]};
    dec_res <= '{dec_req.valid, {dec_req.data[7:0], 8'h00}};
    if (mac_tx.valid === 1'b1) macq.push_back(mac_tx.data);
    if (dec_pcm.valid === 1'b1) pcm_seen <= dec_pcm.data;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata; // read data stand only in this cycle
  endtask
  task automatic rdc(input string nm, input logic [15:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  // cycles between two changes of one clock pin
  task automatic half(input int k, output int h);
    logic v;
    v = clks[k];
    while (clks[k] === v) @(posedge ref_clk);
    v = clks[k];
    h = 0;
    while (clks[k] === v && h < 2000) begin
      @(posedge ref_clk);
      h++;
    end
  endtask
  // count words seen after skipping the settling ones
  task automatic grab(output int gh, output int gl);
    int k;
    gh = 0;
    gl = 0;
    k = 0;
    while (k < 6) begin
      @(posedge ref_clk);
      if (enc_req.valid === 1'b1) begin
        k++;
        lastw = enc_req.data;
        gh += int'(k > 2 && enc_req.data === hi_w);
        gl += int'(k > 2 && enc_req.data === lo_w);
        chk("enc_alg", 16'(ALG_MULAW), 16'(enc_req.alg));
      end
    end
  endtask
  // high frame clock carries left unless polarity is inverted
  function automatic int exp_n(input logic [1:0] m, input logic fp, input logic hi);
    return ((hi ^ fp) ? m[1] : m[0]) ? 2 : 0;
  endfunction
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    rdc("rx_ctrl_rst", A_RX_CTRL, RX_CTRL_RST);
    rdc("rx_mode_rst", A_RX_MODE, RX_MODE_RST);
    rdc("sdiv_rst", A_RX_SDIV, REG_ZERO);
    rdc("unmapped", 16'h2755, REG_ZERO);
    wr(A_ENC_CTRL, 8'hFF);
    rdc("enc_ctrl", A_ENC_CTRL, ENC_RW_MASK);
    wr(A_DEC_CTRL, 8'hFF);
    rdc("dec_ctrl", A_DEC_CTRL, DEC_RW_MASK);
    wr(A_TXP_MODE, 8'h01);
    #1 chk("tx_port_en", 16'h0001, {15'h0000, tx_port_enable});
    for (int i = 0; i < 128; i++) begin
      bank[i] = 8'($random(seed));
      wr(A_TXF_DATA, bank[i]);
    end
    rdc("wp_full", A_TXF_WP, 8'h80);
    wr(A_TXF_DATA, 8'h3C);
    rdc("ovf", A_TXF_ERR, 8'h02);
    for (int i = 0; i < 128; i++) rdc("fifo_order", A_TXF_DATA, bank[i]);
    rdc("rp_wrap", A_TXF_RP, 8'h80);
    rd(A_TXF_DATA);
    rdc("udf", A_TXF_ERR, 8'h03);
    wr(A_TXF_CTRL, 8'h02);
    rdc("clr_err", A_TXF_ERR, REG_ZERO);
    rdc("clr_wp", A_TXF_WP, REG_ZERO);
    // mute value even, stored bytes odd, so a substitution cannot pass unseen
    bank[0] = 8'($random(seed)) & 8'hFE;
    wr(A_TXF_MUTE, bank[0]);
    wr(A_TXF_CTRL, 8'h01);
    rd(A_TXF_STS);
    chk("fill_busy", 16'h0010, {8'h00, d & 8'h10});
    repeat (130) @(posedge ref_clk);
    rd(A_TXF_STS);
    chk("fill_done", 16'h0000, {8'h00, d & 8'h10});
    wr(A_TXF_WP, 8'h05);
    rdc("fill_entry", A_TXF_DATA, bank[0]);
    rdc("rp_step", A_TXF_RP, 8'h01);
    wr(A_TXF_CTRL, 8'h02);
    for (int i = 1; i < 4; i++) begin
      bank[i] = 8'($random(seed)) | 8'h01;
      wr(A_TXF_DATA, bank[i]);
    end
    macq.delete();
    wr(A_DMA_LEN, 8'h02);
    wr(A_TXF_CTRL, 8'h08);
    repeat (300) @(posedge ref_clk);
    chk("dma_count", 16'h0002, 16'(macq.size()));
    chk("dma_byte0", {8'h00, bank[1]}, {8'h00, macq[0]});
    chk("dma_byte1", {8'h00, bank[2]}, {8'h00, macq[1]});
    rdc("dma_selfclr", A_TXF_CTRL, REG_ZERO);
    wr(A_TXF_CTRL, 8'h04);
    rdc("mute_data", A_TXF_DATA, bank[0]);
    rdc("mute_bit", A_TXF_CTRL, 8'h04);
    // master clocks: bit half period 8 cycles, 16 bit slots, mu-law requests
    wr(A_RX_SDIV, 8'h01);
    wr(A_RX_MDIV, 8'h08);
    wr(A_RX_BDIV, 8'h10);
    wr(A_ENC_CTRL, 8'h25);
    wr(A_DEC_CTRL, 8'h81);
    for (int m = 0; m < 4; m++) begin
      for (int fp = 0; fp < 2; fp++) begin
        hi_w = 16'($random(seed)) | 16'h0001;
        lo_w = ~hi_w;
        wr(A_RX_MODE, 8'h58);
        wr(A_RX_CTRL, {1'b1, 2'b01, 2'b00, 1'b0, 1'(fp), 1'b0});
        wr(A_RX_MODE, {5'b01011, 2'(m), 1'b1});
        grab(nh, nl);
        chk("hi_words", 16'(exp_n(2'(m), 1'(fp), 1'b1)), 16'(nh));
        chk("lo_words", 16'(exp_n(2'(m), 1'(fp), 1'b0)), 16'(nl));
      end
    end
    // loopback: the last encoder byte returns through the decoder stand-in
    repeat (6) @(posedge ref_clk);
    chk("loop_pcm", {lastw[15:8], 8'h00}, pcm_seen);
    chk("master_oe", 16'h0001, {15'h0000, mclk_oe});
    half(0, n);
    chk("mclk_half", 16'h0001, 16'(n));
    half(1, n);
    chk("bclk_half", 16'h0008, 16'(n));
    half(2, n);
    chk("frame_clock_half", 16'h0100, 16'(n));
    // slave with shared transmit clocks: bit half period 8 cycles, 16 slots a channel
    wr(A_RX_MODE, 8'h58);
    wr(A_RX_CTRL, 8'h20);
    wr(A_RX_MODE, 8'hDF);
    grab(nh, nl);
    chk("share_hi", 16'h0002, 16'(nh));
    chk("share_lo", 16'h0002, 16'(nl));
    chk("slave_oe", 16'h0000, {15'h0000, bclk_oe});
    complete_run();
  end
endmodule // voice_i2s_rx_codec_txfifo_tb_top
